// file: design/frc_cfg.svh
`ifndef FRC_CFG_SVH
`define FRC_CFG_SVH
// register offsets
`define FRC_OFS_STATUS 4'h1
`define FRC_OFS_CHAN 4'h2
`define FRC_OFS_CONFIG 4'h3
`define FRC_OFS_RANGE_A_LO 4'h4
`define FRC_OFS_RANGE_A_HI 4'h5
`define FRC_OFS_RANGE_B_LO 4'h6
`define FRC_OFS_RANGE_B_HI 4'h7
`define FRC_OFS_OVR_A_PRI 4'h8
`define FRC_OFS_OVR_B_PRI 4'h9
`define FRC_OFS_OVR_A_MIR 4'ha
`define FRC_OFS_OVR_B_MIR 4'hb
// field positions
`define FRC_CFG_FILT_LSB 0
`define FRC_CFG_SEQ_BIT 2
`define FRC_CFG_DIAG_BIT 3
`define FRC_CHAN_A_LSB 0
`define FRC_CHAN_B_LSB 4
// reset values
`define FRC_RST_RANGE 16'hffff
`define FRC_RST_OVR 8'h00
`define FRC_RST_CHAN 8'h00
`define FRC_RST_CONFIG 8'h00
// mux select code of the diagnostic input
`define FRC_DIAG_SEL 4'h8
// timing
`define FRC_SETTLE_US 120
`define FRC_CLK_PERIOD_NS 5
`define FRC_SETTLE_CYCLES (`FRC_SETTLE_US * 1000 / `FRC_CLK_PERIOD_NS)
`endif

// file: design/frc_pkg.sv
package frc_pkg;
  // input range codes, shared by pins and range registers
  typedef enum logic [1:0] {
    FRC_RNG_REG = 2'h0,
    FRC_RNG_2V5 = 2'h1,
    FRC_RNG_5V = 2'h2,
    FRC_RNG_10V = 2'h3
  } frc_range_t;
  // low-pass filter setting
  typedef enum logic [1:0] {
    FRC_LPF_ONE = 2'h0,
    FRC_LPF_TWO = 2'h1,
    FRC_LPF_THREE = 2'h2,
    FRC_LPF_RSVD = 2'h3
  } frc_lpf_t;
  // channel selector states, gray along init, idle, conv
  typedef enum logic [1:0] {
    FRC_SEL_INIT = 2'h0,
    FRC_SEL_IDLE = 2'h1,
    FRC_SEL_CONV = 2'h3
  } frc_sel_state_t;
endpackage

// file: design/frc_sel_if.sv
`timescale 1ns/1ps
`default_nettype none
interface frc_sel_if;
  logic sw_mode; // software mode active
  logic conv_busy; // conversion in progress
  logic seq_en; // sequencer enabled
  logic [2:0] pins; // channel select pins
  logic [3:0] reg_sel_a; // register pick, group a
  logic [3:0] reg_sel_b; // register pick, group b
  logic [3:0] mux_a; // applied mux select, group a
  logic [3:0] mux_b; // applied mux select, group b
  modport ctrl(output sw_mode, conv_busy, seq_en, pins, reg_sel_a,
    reg_sel_b, input mux_a, mux_b);
  modport sel(input sw_mode, conv_busy, seq_en, pins, reg_sel_a,
    reg_sel_b, output mux_a, mux_b);
endinterface
`default_nettype wire

// file: design/frc_chan_sel.sv
`timescale 1ns/1ps
`default_nettype none
`include "frc_cfg.svh"
module frc_chan_sel (
  input wire logic clock, // system clock
  input wire logic reset_n, // async reset, active low
  frc_sel_if.sel bus // selection controls and applied pair
);
  import frc_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // declarations
  frc_sel_state_t state; // selector state
  frc_sel_state_t next_state; // state after this cycle
  logic [2:0] hold_pins; // pins sampled during conversion
  logic [3:0] next_a; // next group a select
  logic [3:0] next_b; // next group b select
  logic hw_bad; // hardware mode with an illegal pair
  logic init_take; // first cycle after reset release
  logic conv_end; // conversion just finished
  logic sw_idle; // software mode follows register when idle
  logic [3:0] pin_pair; // pins as a select code
  logic [3:0] hold_pair; // held pins as a select code

  // register value within the nine mux inputs
  function automatic logic legal(input logic [3:0] s);
    return s <= `FRC_DIAG_SEL;
  endfunction

  // legal register value, or keep the current one
  function automatic logic [3:0] pick(input logic [3:0] r,
    input logic [3:0] cur);
    return legal(r) ? r : cur;
  endfunction

  // sequencer step over the eight group channels
  function automatic logic [3:0] step(input logic [3:0] s);
    return (s >= 4'h7) ? 4'h0 : s + 4'h1;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // decode
  assign pin_pair = {1'b0, bus.pins};
  assign hold_pair = {1'b0, hold_pins};
  // hardware mode forbids diagnostics and unequal pairs
  assign hw_bad = !bus.sw_mode &&
    (bus.mux_a != bus.mux_b || bus.mux_a[3]); // RQ12 RQ17
  assign init_take = state == FRC_SEL_INIT;
  assign conv_end = state == FRC_SEL_CONV && !bus.conv_busy;
  assign sw_idle = state == FRC_SEL_IDLE && bus.sw_mode && !bus.seq_en;

  // group a: pins at reset release, pins held over conversion, register
  assign next_a = hw_bad ? pin_pair :
    init_take ? (bus.sw_mode ? pick(bus.reg_sel_a, bus.mux_a) :
      pin_pair) : // RQ10
    conv_end ? (bus.seq_en ? step(bus.mux_a) : // RQ15
      bus.sw_mode ? pick(bus.reg_sel_a, bus.mux_a) : // RQ13
      hold_pair) : // RQ11
    sw_idle ? pick(bus.reg_sel_a, bus.mux_a) : bus.mux_a;
  // group b: same pins as group a in hardware mode, own register field
  assign next_b = hw_bad ? pin_pair :
    init_take ? (bus.sw_mode ? pick(bus.reg_sel_b, bus.mux_b) :
      pin_pair) :
    conv_end ? (bus.seq_en ? step(bus.mux_b) :
      bus.sw_mode ? pick(bus.reg_sel_b, bus.mux_b) : // RQ18
      hold_pair) : // RQ17
    sw_idle ? pick(bus.reg_sel_b, bus.mux_b) : bus.mux_b;

  // state sequence
  always_comb begin
    case (state)
      FRC_SEL_INIT: next_state = FRC_SEL_IDLE;
      FRC_SEL_IDLE: next_state = bus.conv_busy ? FRC_SEL_CONV : FRC_SEL_IDLE;
      FRC_SEL_CONV: next_state = bus.conv_busy ? FRC_SEL_CONV : FRC_SEL_IDLE;
      default: next_state = FRC_SEL_INIT;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // registers
  // state and applied pair
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state <= FRC_SEL_INIT;
      bus.mux_a <= 4'h0;
      bus.mux_b <= 4'h0;
    end else begin
      state <= next_state;
      bus.mux_a <= next_a;
      bus.mux_b <= next_b;
    end
  end

  // pins watched throughout the conversion
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      hold_pins <= 3'h0;
    end else if (bus.conv_busy) begin
      hold_pins <= bus.pins; // RQ11
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  a_reset_pair_latch: assert property ( // RQ10
    init_take && !bus.sw_mode |=> bus.mux_a == {1'b0, $past(bus.pins)}
  ) else $error("pair not taken from pins at reset release");

  a_conv_pin_sample: assert property ( // RQ11
    conv_end && !bus.sw_mode && !bus.seq_en && !hw_bad
    |=> bus.mux_a == $past(hold_pair) && bus.mux_b == bus.mux_a
  ) else $error("next pair not taken from pins sampled in conversion");

  a_hw_no_diag: assert property ( // RQ12
    !bus.sw_mode [*2] |-> !bus.mux_a[3] && bus.mux_a == bus.mux_b
  ) else $error("diagnostic or split pair in hardware mode");

  a_sw_reg_follow: assert property ( // RQ13
    sw_idle && legal(bus.reg_sel_a) && legal(bus.reg_sel_b)
    |=> bus.mux_a == $past(bus.reg_sel_a) &&
      bus.mux_b == $past(bus.reg_sel_b)
  ) else $error("software pair does not follow register");

  a_seq_step: assert property ( // RQ15
    conv_end && bus.seq_en && !hw_bad
    |=> bus.mux_a == step($past(bus.mux_a))
  ) else $error("sequencer did not advance");
endmodule
`default_nettype wire

// file: design/frc_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "frc_cfg.svh"

// Function
// RQ1: pins 01/10/11 set all ranges 2.5/5/10 V
// RQ2: pins 00 take ranges from registers
// RQ3: software mode keeps per channel range
// RQ4: host writes group a mask twice
// RQ5: host writes group b mask twice
// RQ6: overrange widens enabled channel range fifth
// RQ7: pin change acts at once; settle time
// RQ8: filter 00/01/10 gives options one/two/three
// RQ9: filter programmable only in software mode
// RQ10: pins latched at reset give first pair
// RQ11: pins sampled in conversion give next pair
// RQ12: no diagnostic channels in hardware mode
// RQ13: software mode pair from channel register
// RQ14: nine input mux plus diagnostic pick
// RQ15: sequencer allowed in both modes
// RQ16: range pins choose hardware or software mode
// RQ17: hardware mode pairs channel n with n
// RQ18: software mode pairs any a with b
// RQ19: filter pattern 11 reserved, never applied
module frc_ctrl #(
  parameter int N_CH = 8, // channels per group
  parameter int SETTLE_CYCLES = `FRC_SETTLE_CYCLES // filter two settling
) (
  input wire logic clock, // system clock, 200 MHz
  input wire logic reset_n, // async reset, active low
  input wire logic [1:0] range_select_pins, // range and mode pins
  input wire logic [2:0] channel_select_pins, // pair select pins
  input wire logic conv_busy, // conversion in progress
  input wire logic reg_wr, // register write strobe
  input wire logic reg_rd, // register read strobe
  input wire logic [3:0] reg_addr, // register offset
  input wire logic [7:0] reg_wdata, // write data
  output logic [7:0] reg_rdata, // read data
  output logic sw_mode, // software mode active
  output logic [2*N_CH-1:0] range_a, // range code per group a channel
  output logic [2*N_CH-1:0] range_b, // range code per group b channel
  output logic [N_CH-1:0] overrange_a, // overrange on, group a
  output logic [N_CH-1:0] overrange_b, // overrange on, group b
  output frc_pkg::frc_lpf_t filter_option, // applied filter option
  output logic [3:0] mux_sel_a, // mux select a, 8 is diagnostic
  output logic [3:0] mux_sel_b, // mux select b, 8 is diagnostic
  output logic diag_node, // internal diagnostic node pick
  output logic settling // range change settling window
);
  import frc_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // elaboration checks
  // the register map holds two range bytes per group
  if (N_CH != 8) begin : g_bad_ch
    $error("register layout serves exactly eight channels");
  end
  // window must outlast the eight cycle check and fit the counter
  if (SETTLE_CYCLES < 8 || SETTLE_CYCLES > 32767) begin : g_bad_settle
    $error("settle count must lie between eight and 32767");
  end

  ////////////////////////////////////////////////////////////////////////
  // declarations
  logic [15:0] range_reg_a; // software ranges, group a
  logic [15:0] range_reg_b; // software ranges, group b
  logic [7:0] ovr_a_pri; // overrange mask a, primary
  logic [7:0] ovr_b_pri; // overrange mask b, primary
  logic [7:0] ovr_a_mir; // overrange mask a, mirror
  logic [7:0] ovr_b_mir; // overrange mask b, mirror
  logic [7:0] chan_reg; // software pair select
  logic [7:0] cfg_reg; // filter, sequencer, diagnostic pick
  logic [14:0] settle_cnt; // settling countdown
  logic sw_now; // mode decoded from the pins
  logic [2*N_CH-1:0] next_range_a; // applied range, group a
  logic [2*N_CH-1:0] next_range_b; // applied range, group b
  logic [N_CH-1:0] next_ovr_a; // applied overrange, group a
  logic [N_CH-1:0] next_ovr_b; // applied overrange, group b
  logic [1:0] wr_filt; // filter field written
  logic filt_ok; // filter write accepted
  logic [7:0] next_cfg; // config after a write
  logic range_change; // applied ranges move
  logic settle_load; // start the settling window
  logic [14:0] next_settle_cnt; // countdown after this cycle
  logic [7:0] status; // live status byte
  logic [7:0] next_rdata; // selected read value
  frc_sel_if sel_bus(); // link to the channel selector

  // write strobe aimed at one offset
  function automatic logic wr_hit(input logic [3:0] ofs);
    return reg_wr && reg_addr == ofs;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // mode and range decode
  // both range pins low select software mode
  assign sw_now = range_select_pins == FRC_RNG_REG; // RQ16

  // per channel range, pins in hardware mode, registers in software
  for (genvar gi = 0; gi < N_CH; gi++) begin : g_range
    assign next_range_a[2*gi +: 2] = sw_now ?
      range_reg_a[2*gi +: 2] : range_select_pins; // RQ1 RQ2 RQ3
    assign next_range_b[2*gi +: 2] = sw_now ?
      range_reg_b[2*gi +: 2] : range_select_pins; // RQ1 RQ2 RQ3
  end

  // overrange needs both copies set, and software mode
  assign next_ovr_a = sw_now ? (ovr_a_pri & ovr_a_mir) : '0; // RQ4 RQ6
  assign next_ovr_b = sw_now ? (ovr_b_pri & ovr_b_mir) : '0; // RQ5 RQ6

  ////////////////////////////////////////////////////////////////////////
  // config write decode
  assign wr_filt = reg_wdata[`FRC_CFG_FILT_LSB +: 2];
  // filter changes only in software mode, never to the reserved code
  assign filt_ok = sw_now && wr_filt != FRC_LPF_RSVD; // RQ9 RQ19
  assign next_cfg = {reg_wdata[7:2],
    filt_ok ? wr_filt : cfg_reg[`FRC_CFG_FILT_LSB +: 2]}; // RQ8

  ////////////////////////////////////////////////////////////////////////
  // settling window
  assign range_change = next_range_a != range_a ||
    next_range_b != range_b;
  // only filter two needs the long settle after a range move
  assign settle_load = range_change && filter_option == FRC_LPF_TWO;
  // a further move reloads the full count
  assign next_settle_cnt = settle_load ? 15'(SETTLE_CYCLES) :
    (settle_cnt != 15'h0) ? settle_cnt - 15'h1 : 15'h0; // RQ7

  ////////////////////////////////////////////////////////////////////////
  // read decode
  // status packs the low pair bits, window and mode
  assign status = {mux_sel_b[2:0], mux_sel_a[2:0], settling, sw_mode};
  // unmapped offsets read as zero
  assign next_rdata =
    (reg_addr == `FRC_OFS_STATUS) ? status :
    (reg_addr == `FRC_OFS_CHAN) ? chan_reg :
    (reg_addr == `FRC_OFS_CONFIG) ? cfg_reg :
    (reg_addr == `FRC_OFS_RANGE_A_LO) ? range_reg_a[7:0] :
    (reg_addr == `FRC_OFS_RANGE_A_HI) ? range_reg_a[15:8] :
    (reg_addr == `FRC_OFS_RANGE_B_LO) ? range_reg_b[7:0] :
    (reg_addr == `FRC_OFS_RANGE_B_HI) ? range_reg_b[15:8] :
    (reg_addr == `FRC_OFS_OVR_A_PRI) ? ovr_a_pri :
    (reg_addr == `FRC_OFS_OVR_B_PRI) ? ovr_b_pri :
    (reg_addr == `FRC_OFS_OVR_A_MIR) ? ovr_a_mir :
    (reg_addr == `FRC_OFS_OVR_B_MIR) ? ovr_b_mir : 8'h00;

  ////////////////////////////////////////////////////////////////////////
  // channel selector hookup
  assign sel_bus.sw_mode = sw_now;
  assign sel_bus.conv_busy = conv_busy;
  assign sel_bus.seq_en = cfg_reg[`FRC_CFG_SEQ_BIT]; // RQ15
  assign sel_bus.pins = channel_select_pins;
  assign sel_bus.reg_sel_a = chan_reg[`FRC_CHAN_A_LSB +: 4];
  assign sel_bus.reg_sel_b = chan_reg[`FRC_CHAN_B_LSB +: 4];
  // selector outputs are its own flops
  assign mux_sel_a = sel_bus.mux_a; // RQ14
  assign mux_sel_b = sel_bus.mux_b; // RQ14

  // pair selection for both muxes
  frc_chan_sel u_chan_sel (
    .clock(clock),
    .reset_n(reset_n),
    .bus(sel_bus)
  );

  ////////////////////////////////////////////////////////////////////////
  // register file writes
  // range, channel and config registers
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      range_reg_a <= `FRC_RST_RANGE;
      range_reg_b <= `FRC_RST_RANGE;
      chan_reg <= `FRC_RST_CHAN;
      cfg_reg <= `FRC_RST_CONFIG;
    end else begin
      if (wr_hit(`FRC_OFS_RANGE_A_LO)) range_reg_a[7:0] <= reg_wdata;
      if (wr_hit(`FRC_OFS_RANGE_A_HI)) range_reg_a[15:8] <= reg_wdata;
      if (wr_hit(`FRC_OFS_RANGE_B_LO)) range_reg_b[7:0] <= reg_wdata;
      if (wr_hit(`FRC_OFS_RANGE_B_HI)) range_reg_b[15:8] <= reg_wdata;
      if (wr_hit(`FRC_OFS_CHAN)) chan_reg <= reg_wdata;
      if (wr_hit(`FRC_OFS_CONFIG)) cfg_reg <= next_cfg;
    end
  end

  // overrange masks, both copies
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ovr_a_pri <= `FRC_RST_OVR;
      ovr_b_pri <= `FRC_RST_OVR;
      ovr_a_mir <= `FRC_RST_OVR;
      ovr_b_mir <= `FRC_RST_OVR;
    end else begin
      if (wr_hit(`FRC_OFS_OVR_A_PRI)) ovr_a_pri <= reg_wdata; // RQ4
      if (wr_hit(`FRC_OFS_OVR_B_PRI)) ovr_b_pri <= reg_wdata; // RQ5
      if (wr_hit(`FRC_OFS_OVR_A_MIR)) ovr_a_mir <= reg_wdata; // RQ4
      if (wr_hit(`FRC_OFS_OVR_B_MIR)) ovr_b_mir <= reg_wdata; // RQ5
    end
  end

  // read data, held between reads
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // applied settings, one cycle after the pins or registers
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      sw_mode <= 1'b0;
      range_a <= `FRC_RST_RANGE;
      range_b <= `FRC_RST_RANGE;
      overrange_a <= '0;
      overrange_b <= '0;
    end else begin
      sw_mode <= sw_now; // RQ16
      range_a <= next_range_a; // RQ7
      range_b <= next_range_b; // RQ7
      overrange_a <= next_ovr_a; // RQ6
      overrange_b <= next_ovr_b; // RQ6
    end
  end

  // filter, diagnostic pick and settling window
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      filter_option <= FRC_LPF_ONE;
      diag_node <= 1'b0;
      settle_cnt <= 15'h0;
      settling <= 1'b0;
    end else begin
      filter_option <= frc_lpf_t'(cfg_reg[`FRC_CFG_FILT_LSB +: 2]); // RQ8
      diag_node <= cfg_reg[`FRC_CFG_DIAG_BIT]; // RQ14
      settle_cnt <= next_settle_cnt;
      settling <= next_settle_cnt != 15'h0; // RQ7
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  // range application
  a_hw_range_all: assert property ( // RQ1
    !sw_now |=> range_a == {N_CH{$past(range_select_pins)}} &&
      range_b == range_a
  ) else $error("hardware range not applied to every channel");

  a_sw_range_reg: assert property ( // RQ2
    sw_now |=> range_a == $past(range_reg_a) &&
      range_b == $past(range_reg_b)
  ) else $error("software range not taken from registers");

  // overrange, mode and diagnostic pick
  a_ovr_both_copies: assert property ( // RQ6
    1'b1 |=> overrange_a == ($past(sw_now) ?
      $past(ovr_a_pri) & $past(ovr_a_mir) : 8'h00)
  ) else $error("overrange mask misapplied");

  a_ovr_b_copies: assert property ( // RQ6
    1'b1 |=> overrange_b == ($past(range_select_pins) == 2'h0 ?
      $past(ovr_b_pri) & $past(ovr_b_mir) : 8'h00)
  ) else $error("group b overrange mask misapplied");

  a_mode_follow: assert property ( // RQ16
    1'b1 |=> sw_mode == ($past(range_select_pins) == 2'h0)
  ) else $error("mode does not follow range pins");

  a_diag_follow: assert property ( // RQ14
    1'b1 |=> diag_node == $past(cfg_reg[`FRC_CFG_DIAG_BIT])
  ) else $error("diagnostic node pick not applied");

  // filter field
  a_filt_hw_lock: assert property ( // RQ9
    !sw_now ##1 !sw_now [*2] |-> $stable(filter_option)
  ) else $error("filter changed in hardware mode");

  a_filt_rsvd: assert property ( // RQ19
    filter_option != FRC_LPF_RSVD
  ) else $error("reserved filter code applied");

  a_filt_sw_write: assert property ( // RQ8
    reg_wr && reg_addr == `FRC_OFS_CONFIG && range_select_pins == 2'h0 &&
      wr_filt != 2'h3 |=> ##1 filter_option == $past(wr_filt, 2)
  ) else $error("software filter write not applied");

  // settling window

  a_settle_window: assert property ( // RQ7
    settle_load |=> settling [*8]
  ) else $error("settling window did not open");

  a_settle_close: assert property ( // RQ7
    settle_cnt == 15'h1 && !settle_load |=> !settling
  ) else $error("settling window did not close");
endmodule
`default_nettype wire

// file: verif/frc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////
// host side: drives mode pins, conversions and register strobes
module frc_host_model (
  input wire logic clock, // system clock
  output logic [1:0] range_select_pins, // range and mode pins
  output logic [2:0] channel_select_pins, // pair select pins
  output logic conv_busy, // conversion in progress
  output logic reg_wr, // write strobe
  output logic reg_rd, // read strobe
  output logic [3:0] reg_addr, // register offset
  output logic [7:0] reg_wdata, // write data
  input wire logic [7:0] reg_rdata // read data
);
  // idle values at time zero, hardware mode at ten volts
  initial begin
    range_select_pins = 2'h3;
    channel_select_pins = 3'h5;
    conv_busy = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'hf;
    reg_wdata = 8'h00;
  end
  ////////////////////////////////////////////////////////////////////////////
  // one access held over one rising edge; released bus shows inverse
  task automatic access(input logic wr, input logic [3:0] a,
    input logic [7:0] d, output logic [7:0] q);
    @(negedge clock);
    reg_wr = wr;
    reg_rd = !wr;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clock);
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
    q = reg_rdata;
  endtask
  // one write, strobe held for one rising edge
  task automatic write_reg(input logic [3:0] a, input logic [7:0] d);
    logic [7:0] q; // read data, unused on a write
    access(1'b1, a, d, q);
  endtask
  // one read, data taken half a cycle after the strobe edge
  task automatic read_reg(input logic [3:0] a, output logic [7:0] d);
    access(1'b0, a, 8'h00, d);
  endtask
  // overrange mask goes to both copies of a group
  task automatic write_overrange(input logic grp_b, input logic [7:0] m);
    write_reg({3'h4, grp_b}, m);
    write_reg({3'h5, grp_b}, m);
  endtask
  // range pins change off the sampling edge
  task automatic set_range_pins(input logic [1:0] p);
    @(negedge clock);
    range_select_pins = p;
  endtask
  // conversion with the next pair held on the pins throughout
  task automatic convert(input logic [2:0] p);
    @(negedge clock);
    channel_select_pins = p;
    conv_busy = 1'b1;
    repeat (4) @(negedge clock);
    conv_busy = 1'b0;
    repeat (4) @(negedge clock);
  endtask
endmodule
`default_nettype wire

// file: verif/tb_frontend_range_mux_control.sv
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////
// bench top: host model drives the block, sequences compare its outputs
module tb_frontend_range_mux_control;
  import frc_pkg::*;
  localparam int SETTLE = 20; // shortened settling window
  logic clock; // system clock
  logic reset_n; // reset, active low
  logic [1:0] range_select_pins; // mode pins
  logic [2:0] channel_select_pins; // pair pins
  logic conv_busy, reg_wr, reg_rd; // host strobes
  logic [3:0] reg_addr; // offset
  logic [7:0] reg_wdata, reg_rdata; // data
  logic sw_mode, diag_node, settling; // status outputs
  logic [15:0] range_a, range_b; // applied ranges
  logic [7:0] overrange_a, overrange_b; // applied overrange
  frc_lpf_t filter_option; // applied filter
  logic [3:0] mux_sel_a, mux_sel_b; // applied pair
  logic [7:0] rd; // read result
  int num_errors, n_tests, cnt; // counters
  ////////////////////////////////////////////////////////////////////////////
  // clock, 5 ns period
  initial clock = 1'b0;
  always #2.5 clock = ~clock;
  frc_host_model u_host (.clock(clock),
    .range_select_pins(range_select_pins),
    .channel_select_pins(channel_select_pins), .conv_busy(conv_busy),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  frc_ctrl #(.SETTLE_CYCLES(SETTLE)) u_dut (.clock(clock),
    .reset_n(reset_n), .range_select_pins(range_select_pins),
    .channel_select_pins(channel_select_pins), .conv_busy(conv_busy),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .sw_mode(sw_mode),
    .range_a(range_a), .range_b(range_b), .overrange_a(overrange_a),
    .overrange_b(overrange_b), .filter_option(filter_option),
    .mux_sel_a(mux_sel_a), .mux_sel_b(mux_sel_b), .diag_node(diag_node),
    .settling(settling));
  ////////////////////////////////////////////////////////////////////////////
  // value compare, four-state
  task automatic check(input string what, input logic [15:0] got,
    input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t ns %s: got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic pause(input int n);
    repeat (n) @(negedge clock);
  endtask
  task automatic done(input string name);
    $display("test %s done", name);
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    reset_n = 1'b0;
    num_errors = 0;
    n_tests = 0;
    pause(2);
    check("reset range", range_a, 16'hffff);
    check("reset pair", 16'({mux_sel_a, mux_sel_b}), 16'h0000);
    check("reset ovr", {overrange_a, overrange_b}, 16'h0000);
    check("reset filter", 16'(filter_option), 16'h0000);
    pause(2);
    reset_n = 1'b1;
    pause(3);
    check("first pair", 16'({mux_sel_a, mux_sel_b}), 16'h0055);
    check("hw mode", 16'(sw_mode), 16'h0000);
    for (int p = 1; p < 4; p++) begin
      u_host.set_range_pins(p[1:0]);
      pause(3);
      check("hw range a", range_a, {8{p[1:0]}});
      check("hw range b", range_b, {8{p[1:0]}});
    end
    u_host.write_reg(4'h3, 8'h01);
    u_host.write_overrange(1'b0, 8'h0f);
    pause(3);
    check("hw filter", 16'(filter_option), 16'h0000);
    u_host.convert(3'h3);
    check("hw next pair", 16'({mux_sel_a, mux_sel_b}), 16'h0033);
    u_host.read_reg(4'h1, rd);
    check("status", 16'(rd), 16'h006c);
    u_host.write_reg(4'hc, 8'h5a);
    u_host.read_reg(4'hc, rd);
    check("unmapped", 16'(rd), 16'h0000);
    done("hardware");
    u_host.set_range_pins(2'h0);
    pause(3);
    check("sw mode", 16'(sw_mode), 16'h0001);
    check("sw reg range", range_a, 16'hffff);
    check("sw ovr a", 16'(overrange_a), 16'h000f);
    u_host.read_reg(4'ha, rd);
    check("ovr mirror", 16'(rd), 16'h000f);
    u_host.write_reg(4'h4, 8'he4);
    u_host.write_reg(4'h5, 8'h1b);
    u_host.write_reg(4'h6, 8'h55);
    u_host.write_reg(4'h7, 8'haa);
    u_host.write_reg(4'h9, 8'ha5);
    pause(3);
    check("per ch a", range_a, 16'h1be4);
    check("per ch b", range_b, 16'haa55);
    check("one copy", 16'(overrange_b), 16'h0000);
    u_host.write_reg(4'hb, 8'ha5);
    pause(3);
    check("both copies", 16'(overrange_b), 16'h00a5);
    done("ranges");
    u_host.write_reg(4'h2, 8'h62);
    pause(3);
    check("any pair", 16'({mux_sel_a, mux_sel_b}), 16'h0026);
    u_host.write_reg(4'h2, 8'h88);
    u_host.write_reg(4'h3, 8'h08);
    pause(3);
    check("diag pair", 16'({mux_sel_a, mux_sel_b}), 16'h0088);
    check("diag node", 16'(diag_node), 16'h0001);
    u_host.write_reg(4'h2, 8'h9a);
    pause(3);
    check("bad pair", 16'({mux_sel_a, mux_sel_b}), 16'h0088);
    u_host.write_reg(4'h2, 8'h77);
    u_host.write_reg(4'h3, 8'h04);
    u_host.convert(3'h6);
    check("seq wrap", 16'({mux_sel_a, mux_sel_b}), 16'h0000);
    u_host.convert(3'h6);
    check("seq step", 16'({mux_sel_a, mux_sel_b}), 16'h0011);
    done("channels");
    for (int f = 0; f < 3; f++) begin
      u_host.write_reg(4'h3, f[7:0]);
      pause(3);
      check("filter", 16'(filter_option), f[15:0]);
    end
    u_host.write_reg(4'h3, 8'h03);
    pause(3);
    check("filter rsvd", 16'(filter_option), 16'h0002);
    u_host.write_reg(4'h3, 8'h01);
    u_host.set_range_pins(2'h3);
    cnt = 0;
    for (int i = 0; i < 10 && settling !== 1'b1; i++) @(negedge clock);
    while (settling === 1'b1 && cnt < 100) begin
      cnt++;
      @(negedge clock);
    end
    check("settle len", cnt[15:0], SETTLE[15:0]);
    done("filter");
    u_host.set_range_pins(2'h0);
    u_host.write_reg(4'h2, 8'h88);
    pause(3);
    u_host.set_range_pins(2'h3);
    pause(3);
    check("hw no diag", 16'({mux_sel_a, mux_sel_b}), 16'h0066);
    done("diag refusal");
    summarize();
  end
endmodule
`default_nettype wire
